/* File: design/iop_pad_storage.sv */
// Top of the pad cell storage: six elements, clock routing and dual-edge muxes
`timescale 1ns/1ps
module iop_pad_storage #(
    parameter bit OUT_CE_CONNECTED = 1'b1,
    parameter bit TRI_CE_CONNECTED = 1'b1,
    parameter bit IN_CE_CONNECTED  = 1'b1,
    parameter int NUM_ELEM         = iop_pkg::NUM_ELEM
) (
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    input  wire logic                                   outTriClockUpper,
    input  wire logic                                   outTriClockLower,
    input  wire logic                                   inClockUpper,
    input  wire logic                                   inClockLower,
    input  wire logic                                   outPairClockEnable,
    input  wire logic                                   triPairClockEnable,
    input  wire logic                                   inPairClockEnable,
    input  wire logic                                   setResetLine,
    input  wire logic                                   reverseForceLine,
    input  wire logic                                   globalSetReset,
    input  wire logic                                   outDualEdge,
    input  wire logic                                   triDualEdge,
    input  wire iop_pkg::iop_pair_s                     outData,
    input  wire iop_pkg::iop_pair_s                     triData,
    input  wire logic                                   padIn,
    input  wire iop_pkg::iop_cfg_s [iop_pkg::NUM_ELEM-1:0] elemCfg,
    output iop_pkg::iop_pair_s                          inCapture,
    output iop_pkg::iop_pair_s                          outStored,
    output iop_pkg::iop_pair_s                          triStored,
    output logic                                        padOut,
    output logic                                        padOutEnable
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (NUM_ELEM != iop_pkg::NUM_ELEM) begin : g_bad_count
        $error("pad cell holds exactly six storage elements");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock, enable and data routing per element
    logic [NUM_ELEM-1:0]    elemClk;
    logic [NUM_ELEM-1:0]    elemCe;
    logic [NUM_ELEM-1:0]    elemD;
    logic [NUM_ELEM-1:0]    elemQ;
    logic [NUM_ELEM-1:0]    elemDdr;
    logic [NUM_ELEM-1:0]    polarity;
    logic [NUM_ELEM-1:0]    initOwn;
    logic [NUM_ELEM-1:0]    initFinal;
    logic [2:0]             ceEff;
    logic                   initPending_r;
    iop_pkg::iop_elem_cfg_s [NUM_ELEM-1:0] elemCfgEff;

    // An enable that is not wired in reads as asserted
    assign ceEff[iop_pkg::CE_IN]  = inPairClockEnable  | ~IN_CE_CONNECTED;
    assign ceEff[iop_pkg::CE_OUT] = outPairClockEnable | ~OUT_CE_CONNECTED;
    assign ceEff[iop_pkg::CE_TRI] = triPairClockEnable | ~TRI_CE_CONNECTED;

    assign elemClk[iop_pkg::IDX_IN_UP]  = inClockUpper;
    assign elemClk[iop_pkg::IDX_IN_LO]  = inClockLower;
    assign elemClk[iop_pkg::IDX_OUT_UP] = outTriClockUpper;
    assign elemClk[iop_pkg::IDX_TRI_UP] = outTriClockUpper;
    assign elemClk[iop_pkg::IDX_OUT_LO] = outTriClockLower;
    assign elemClk[iop_pkg::IDX_TRI_LO] = outTriClockLower;

    assign elemCe[iop_pkg::IDX_IN_UP]  = ceEff[iop_pkg::CE_IN];
    assign elemCe[iop_pkg::IDX_IN_LO]  = ceEff[iop_pkg::CE_IN];
    assign elemCe[iop_pkg::IDX_OUT_UP] = ceEff[iop_pkg::CE_OUT];
    assign elemCe[iop_pkg::IDX_OUT_LO] = ceEff[iop_pkg::CE_OUT];
    assign elemCe[iop_pkg::IDX_TRI_UP] = ceEff[iop_pkg::CE_TRI];
    assign elemCe[iop_pkg::IDX_TRI_LO] = ceEff[iop_pkg::CE_TRI];

    assign elemD[iop_pkg::IDX_IN_UP]  = padIn;
    assign elemD[iop_pkg::IDX_IN_LO]  = padIn;
    assign elemD[iop_pkg::IDX_OUT_UP] = outData.upper;
    assign elemD[iop_pkg::IDX_OUT_LO] = outData.lower;
    assign elemD[iop_pkg::IDX_TRI_UP] = triData.upper;
    assign elemD[iop_pkg::IDX_TRI_LO] = triData.lower;

    assign elemDdr[iop_pkg::IDX_IN_UP]  = 1'h0;
    assign elemDdr[iop_pkg::IDX_IN_LO]  = 1'h0;
    assign elemDdr[iop_pkg::IDX_OUT_UP] = outDualEdge;
    assign elemDdr[iop_pkg::IDX_OUT_LO] = outDualEdge;
    assign elemDdr[iop_pkg::IDX_TRI_UP] = triDualEdge;
    assign elemDdr[iop_pkg::IDX_TRI_LO] = triDualEdge;

    ////////////////////////////////////////////////////////////////////////////
    // Initial-state load once reset releases, standing in for end of configuration
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            initPending_r <= 1'h1;
        end else begin
            initPending_r <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Resolve options; even index is upper, odd index is lower of a pair
    for (genvar k = 0; k < NUM_ELEM; k++) begin : g_elem
        localparam int UP = k - (k % 2);
        localparam int LO = UP + 1;

        // A lower element in dual-edge use copies the upper polarity
        assign polarity[k] = (elemDdr[k] && (k % 2 == 1)) ?
                             elemCfg[UP].forceToOne : elemCfg[k].forceToOne;
        assign initOwn[k]  = elemCfg[k].initialOverride ?
                             elemCfg[k].initialOne : polarity[k];
        // Dual-edge use: a zero choice in either element of the pair pulls both to zero
        assign initFinal[k] = elemDdr[k] ? (initOwn[UP] & initOwn[LO]) : initOwn[k];

        assign elemCfgEff[k].isLatch    = elemCfg[k].elementTypeSelect;
        assign elemCfgEff[k].isAsync    = elemCfg[k].setResetTimingSelect;
        assign elemCfgEff[k].forceToOne = polarity[k];
        assign elemCfgEff[k].initialOne = initFinal[k];

        iop_storage_element u_elem (
            .clock            (clock),
            .rst              (rst),
            .clkLine          (elemClk[k]),
            .clkEnable        (elemCe[k]),
            .dataIn           (elemD[k]),
            .setResetLine     (setResetLine),
            .reverseForceLine (reverseForceLine),
            .globalSetReset   (globalSetReset),
            .initPending      (initPending_r),
            .cfg              (elemCfgEff[k]),
            .q                (elemQ[k])
        );
    end

    assign inCapture.upper = elemQ[iop_pkg::IDX_IN_UP];
    assign inCapture.lower = elemQ[iop_pkg::IDX_IN_LO];
    assign outStored.upper = elemQ[iop_pkg::IDX_OUT_UP];
    assign outStored.lower = elemQ[iop_pkg::IDX_OUT_LO];
    assign triStored.upper = elemQ[iop_pkg::IDX_TRI_UP];
    assign triStored.lower = elemQ[iop_pkg::IDX_TRI_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Dual-edge mux: the two output clocks run in opposite phase, so the upper
    // element shows after the rising edge and the lower after the falling one
    logic upperClkPrev_r;
    logic lowerClkPrev_r;
    logic showLower_r;
    logic upperRise;
    logic lowerRise;
    logic padOut_r;
    logic padOutEnable_r;
    logic outBit;
    logic triBit;

    assign upperRise = outTriClockUpper & ~upperClkPrev_r;
    assign lowerRise = outTriClockLower & ~lowerClkPrev_r;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            upperClkPrev_r <= 1'h0;
            lowerClkPrev_r <= 1'h0;
        end else begin
            upperClkPrev_r <= outTriClockUpper;
            lowerClkPrev_r <= outTriClockLower;
        end
    end

    // Select follows whichever clock edge came last, lower winning a tie; the load lands one cycle later
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            showLower_r <= iop_pkg::RESET_SEL;
        end else if (lowerRise) begin
            showLower_r <= 1'h1;
        end else if (upperRise) begin
            showLower_r <= 1'h0;
        end
    end

    assign outBit = (outDualEdge && showLower_r) ? outStored.lower : outStored.upper;
    assign triBit = (triDualEdge && showLower_r) ? triStored.lower : triStored.upper;

    // Tri element high means the driver floats
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            padOut_r       <= 1'h0;
            padOutEnable_r <= 1'h0;
        end else begin
            padOut_r       <= outBit;
            padOutEnable_r <= ~triBit;
        end
    end

    assign padOut       = padOut_r;
    assign padOutEnable = padOutEnable_r;

    ////////////////////////////////////////////////////////////////////////////
    chk_ddr_shows_lower: assert property (
        @(posedge clock) disable iff (rst)
        (outDualEdge && showLower_r) |=> (padOut == $past(outStored.lower)))
        else $error("dual-edge output did not show lower element");

    chk_ddr_shows_upper: assert property (
        @(posedge clock) disable iff (rst)
        (outDualEdge && !showLower_r) |=> (padOut == $past(outStored.upper)))
        else $error("dual-edge output did not show upper element");

    chk_pad_enable_tri: assert property (
        @(posedge clock) disable iff (rst)
        !triDualEdge |=> (padOutEnable == !$past(triStored.upper)))
        else $error("driver enable does not follow tri element");

    chk_lower_polarity: assert property (
        @(posedge clock) disable iff (rst)
        outDualEdge |-> (elemCfgEff[iop_pkg::IDX_OUT_LO].forceToOne ==
                         elemCfg[iop_pkg::IDX_OUT_UP].forceToOne))
        else $error("dual-edge lower element ignores upper polarity");

    chk_init_pair_zero: assert property (
        @(posedge clock) disable iff (rst)
        (outDualEdge && !initOwn[iop_pkg::IDX_OUT_UP]) |->
        (!initFinal[iop_pkg::IDX_OUT_LO]))
        else $error("initial zero did not reach both elements");

    chk_shared_out_clock: assert property (
        @(posedge clock) disable iff (rst)
        elemClk[iop_pkg::IDX_OUT_UP] == elemClk[iop_pkg::IDX_TRI_UP])
        else $error("upper output and tri clocks differ");

    ////////////////////////////////////////////////////////////////////////////
    // Pair loads, enables and mux select; forcing and init loads are left to the element checks
    sequence seq_no_force;
        !setResetLine && !reverseForceLine && !globalSetReset && !initPending_r;
    endsequence

    sequence seq_upper_load;
        !outTriClockUpper ##1
        (outTriClockUpper && ceEff[iop_pkg::CE_OUT] && ceEff[iop_pkg::CE_TRI]);
    endsequence

    sequence seq_lower_load;
        !outTriClockLower ##1
        (outTriClockLower && ceEff[iop_pkg::CE_OUT] && ceEff[iop_pkg::CE_TRI]);
    endsequence

    chk_upper_pair_load: assert property (
        @(posedge clock) disable iff (rst)
        seq_upper_load ##0 (seq_no_force and (!elemCfgEff[iop_pkg::IDX_OUT_UP].isLatch &&
                                              !elemCfgEff[iop_pkg::IDX_TRI_UP].isLatch))
        |=> (outStored.upper == $past(outData.upper) && triStored.upper == $past(triData.upper)))
        else $error("upper output and tri elements did not load together");

    chk_lower_pair_load: assert property (
        @(posedge clock) disable iff (rst)
        seq_lower_load ##0 (seq_no_force and (!elemCfgEff[iop_pkg::IDX_OUT_LO].isLatch &&
                                              !elemCfgEff[iop_pkg::IDX_TRI_LO].isLatch))
        |=> (outStored.lower == $past(outData.lower) && triStored.lower == $past(triData.lower)))
        else $error("lower output and tri elements did not load together");

    chk_input_upper_load: assert property (
        @(posedge clock) disable iff (rst)
        (!inClockUpper ##1 (inClockUpper && ceEff[iop_pkg::CE_IN])) ##0
        (seq_no_force and !elemCfgEff[iop_pkg::IDX_IN_UP].isLatch)
        |=> (inCapture.upper == $past(padIn)))
        else $error("input upper element did not load on its own clock");

    chk_out_enable_holds: assert property (
        @(posedge clock) disable iff (rst)
        (seq_no_force and !ceEff[iop_pkg::CE_OUT]) |=> $stable(outStored))
        else $error("output pair changed while its enable was low");

    chk_tri_enable_holds: assert property (
        @(posedge clock) disable iff (rst)
        (seq_no_force and !ceEff[iop_pkg::CE_TRI]) |=> $stable(triStored))
        else $error("tri pair changed while its enable was low");

    chk_in_enable_holds: assert property (
        @(posedge clock) disable iff (rst)
        (seq_no_force and !ceEff[iop_pkg::CE_IN]) |=> $stable(inCapture))
        else $error("input pair changed while its enable was low");

    chk_select_takes_lower: assert property (
        @(posedge clock) disable iff (rst)
        lowerRise |=> showLower_r)
        else $error("select did not move to the lower element");

    chk_select_takes_upper: assert property (
        @(posedge clock) disable iff (rst)
        (upperRise && !lowerRise) |=> !showLower_r)
        else $error("select did not move to the upper element");

    chk_plain_shows_upper: assert property (
        @(posedge clock) disable iff (rst)
        !outDualEdge |=> (padOut == $past(outStored.upper)))
        else $error("plain output pair did not show upper element");

    chk_tri_shows_lower: assert property (
        @(posedge clock) disable iff (rst)
        (triDualEdge && showLower_r) |=> (padOutEnable == !$past(triStored.lower)))
        else $error("dual-edge tri pair did not show lower element");

endmodule : iop_pad_storage

/* File: design/iop_pkg.sv */
// Package with layout, configuration types and indices of the pad storage elements
package iop_pkg;

    localparam int unsigned NUM_ELEM   = 6;
    localparam int unsigned ELEM_IDX_W = 3;

    // Element positions inside the cell
    localparam int unsigned IDX_IN_UP  = 0;
    localparam int unsigned IDX_IN_LO  = 1;
    localparam int unsigned IDX_OUT_UP = 2;
    localparam int unsigned IDX_OUT_LO = 3;
    localparam int unsigned IDX_TRI_UP = 4;
    localparam int unsigned IDX_TRI_LO = 5;

    // Enable port positions
    localparam int unsigned CE_IN  = 0;
    localparam int unsigned CE_OUT = 1;
    localparam int unsigned CE_TRI = 2;

    // Value of the element right after reset release, before init loads
    localparam logic RESET_Q   = 1'h0;
    // Value taken when set/reset and reverse collide
    localparam logic CLASH_Q   = 1'h0;
    // Select value of the dual-edge mux after reset
    localparam logic RESET_SEL = 1'h0;

    // Per-element options as software configures them
    typedef struct packed {
        logic elementTypeSelect;      // 1 = level latch, 0 = edge flip-flop
        logic setResetTimingSelect;   // 1 = asynchronous, 0 = synchronous
        logic forceToOne;             // 1 = set polarity, 0 = reset polarity
        logic initialOverride;        // 1 = use initialOne, 0 = follow polarity
        logic initialOne;             // 1 = initial one, 0 = initial zero
    } iop_cfg_s;

    // Options after pairing exceptions are resolved
    typedef struct packed {
        logic isLatch;
        logic isAsync;
        logic forceToOne;
        logic initialOne;
    } iop_elem_cfg_s;

    // One upper and one lower bit of a path
    typedef struct packed {
        logic upper;
        logic lower;
    } iop_pair_s;

endpackage : iop_pkg

/* File: design/iop_storage_element.sv */
// One configurable storage element of the pad cell
`timescale 1ns/1ps
module iop_storage_element (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   clkLine,
    input  wire logic                   clkEnable,
    input  wire logic                   dataIn,
    input  wire logic                   setResetLine,
    input  wire logic                   reverseForceLine,
    input  wire logic                   globalSetReset,
    input  wire logic                   initPending,
    input  wire iop_pkg::iop_elem_cfg_s cfg,
    output logic                        q
);

    logic clkLinePrev_r;
    logic q_r;
    logic q_nxt;
    logic activeEdge;
    logic transparent;
    logic forceAny;
    logic forceVal;

    assign activeEdge  = clkLine & ~clkLinePrev_r;
    assign transparent = clkLine & clkEnable;
    assign forceAny    = setResetLine | reverseForceLine;
    // Reverse drives the opposite of set/reset; a clash gives zero
    assign forceVal    = (setResetLine & reverseForceLine) ? iop_pkg::CLASH_Q :
                         (setResetLine ? cfg.forceToOne : ~cfg.forceToOne);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkLinePrev_r <= 1'h0;
        end else begin
            clkLinePrev_r <= clkLine;
        end
    end

    always_comb begin
        q_nxt = q_r;
        if (initPending || globalSetReset) begin
            q_nxt = cfg.initialOne;
        end else if (forceAny && (cfg.isAsync || (cfg.isLatch ? transparent : activeEdge))) begin
            q_nxt = forceVal;
        end else if (cfg.isLatch) begin
            if (transparent) begin
                q_nxt = dataIn;
            end
        end else if (activeEdge && clkEnable) begin
            q_nxt = dataIn;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q_r <= iop_pkg::RESET_Q;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

    ////////////////////////////////////////////////////////////////////////////
    sequence seq_quiet;
        !initPending && !globalSetReset;
    endsequence

    sequence seq_rise;
        !clkLine ##1 (clkLine && clkEnable && !forceAny && !cfg.isLatch);
    endsequence

    chk_clash_gives_zero: assert property (
        @(posedge clock) disable iff (rst)
        (seq_quiet and (setResetLine && reverseForceLine && cfg.isAsync)) |=> (q == 1'b0))
        else $error("set/reset and reverse together did not give zero");

    chk_async_force_value: assert property (
        @(posedge clock) disable iff (rst)
        (seq_quiet and (setResetLine && !reverseForceLine && cfg.isAsync))
        |=> (q == $past(cfg.forceToOne)))
        else $error("asynchronous set/reset gave wrong value");

    chk_reverse_opposite: assert property (
        @(posedge clock) disable iff (rst)
        (seq_quiet and (reverseForceLine && !setResetLine && cfg.isAsync))
        |=> (q == !$past(cfg.forceToOne)))
        else $error("reverse did not force the opposite value");

    chk_sync_waits_edge: assert property (
        @(posedge clock) disable iff (rst)
        (seq_quiet and (forceAny && !cfg.isAsync && !cfg.isLatch && !activeEdge))
        |=> $stable(q))
        else $error("synchronous set/reset acted without a clock edge");

    chk_global_init: assert property (
        @(posedge clock) disable iff (rst)
        (globalSetReset || initPending) |=> (q == $past(cfg.initialOne)))
        else $error("initial state not loaded");

    chk_flop_loads_edge: assert property (
        @(posedge clock) disable iff (rst)
        seq_rise ##0 seq_quiet |=> (q == $past(dataIn)))
        else $error("flip-flop did not load on enabled edge");

    chk_enable_gates: assert property (
        @(posedge clock) disable iff (rst)
        (seq_quiet and (!clkEnable && !forceAny)) |=> $stable(q))
        else $error("element changed while its enable was low");

    chk_latch_passes: assert property (
        @(posedge clock) disable iff (rst)
        (seq_quiet and (cfg.isLatch && transparent && !forceAny)) |=> (q == $past(dataIn)))
        else $error("open latch did not pass its data");

endmodule : iop_storage_element

/* File: sim/iop_fabric_model.sv */
// Fabric side model that drives the shared output and tri clock lines
`timescale 1ns/1ps
module iop_fabric_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic dualRun,
    input  wire logic manUpper,
    input  wire logic manLower,
    output logic      outTriClockUpper,
    output logic      outTriClockLower
);
    logic [1:0] phase_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase stands still unless dual-edge traffic runs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= dualRun ? phase_r + 2'h1 : 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Opposite phase while dualRun is set, so that upper and lower never rise together; otherwise manUpper and manLower pass through
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            outTriClockUpper <= 1'h0;
            outTriClockLower <= 1'h0;
        end else if (dualRun) begin
            outTriClockUpper <= ~phase_r[1];
            outTriClockLower <= phase_r[1];
        end else begin
            outTriClockUpper <= manUpper;
            outTriClockLower <= manLower;
        end
    end
endmodule : iop_fabric_model

/* File: sim/io_pad_storage_registers_bench.sv */
// Self-checking bench of the pad cell storage
`timescale 1ns/1ps
module io_pad_storage_registers_bench;
    typedef struct packed {
        iop_pkg::iop_cfg_s c;
        logic              d;
        logic              fwd;
        logic              inv;
        logic              q;
    } iop_row_s;
    logic clock, rst, ckUp, ckLo, inClockUpper, inClockLower, outCe, triCe, inCe;
    logic setResetLine, reverseForceLine, globalSetReset, outDualEdge, triDualEdge;
    logic padIn, padOut, padOutEnable, dualRun, manUpper, manLower;
    iop_pkg::iop_pair_s outData, triData, inCapture, outStored, triStored;
    iop_pkg::iop_cfg_s [iop_pkg::NUM_ELEM-1:0] elemCfg;
    int error_cnt, samples_checked, k, flips;
    logic prevOut;
    iop_row_s rows [10] = '{
        '{5'h00, 1'h1, 1'h0, 1'h0, 1'h1}, '{5'h00, 1'h0, 1'h0, 1'h0, 1'h0},
        '{5'h04, 1'h0, 1'h1, 1'h0, 1'h1}, '{5'h00, 1'h1, 1'h1, 1'h0, 1'h0},
        '{5'h04, 1'h1, 1'h0, 1'h1, 1'h0}, '{5'h00, 1'h0, 1'h0, 1'h1, 1'h1},
        '{5'h04, 1'h1, 1'h1, 1'h1, 1'h0}, '{5'h0c, 1'h0, 1'h1, 1'h0, 1'h1},
        '{5'h08, 1'h1, 1'h1, 1'h1, 1'h0}, '{5'h08, 1'h0, 1'h0, 1'h1, 1'h1}};
    logic [3:0] clkMask [4] = '{4'h2, 4'h1, 4'h8, 4'h4};
    logic [5:0] clkExp [4] = '{6'h01, 6'h03, 6'h17, 6'h3f};

    iop_fabric_model fabric (.clock(clock), .rst(rst), .dualRun(dualRun), .manUpper(manUpper),
        .manLower(manLower), .outTriClockUpper(ckUp), .outTriClockLower(ckLo));
    iop_pad_storage dut (.clock(clock), .rst(rst), .outTriClockUpper(ckUp),
        .outTriClockLower(ckLo), .inClockUpper(inClockUpper), .inClockLower(inClockLower),
        .outPairClockEnable(outCe), .triPairClockEnable(triCe), .inPairClockEnable(inCe),
        .setResetLine(setResetLine), .reverseForceLine(reverseForceLine),
        .globalSetReset(globalSetReset), .outDualEdge(outDualEdge), .triDualEdge(triDualEdge),
        .outData(outData), .triData(triData), .padIn(padIn), .elemCfg(elemCfg),
        .inCapture(inCapture), .outStored(outStored), .triStored(triStored),
        .padOut(padOut), .padOutEnable(padOutEnable));

    initial begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [5:0] got, input logic [5:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
            error_cnt++;
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // Bit i of the result is element i of the cell
    function automatic logic [5:0] elems();
        return {triStored.lower, triStored.upper, outStored.lower, outStored.upper,
                inCapture.lower, inCapture.upper};
    endfunction : elems

    task automatic pulse(input logic [3:0] mask);
        {manUpper, manLower, inClockUpper, inClockLower} <= mask;
        tick(2);
        {manUpper, manLower, inClockUpper, inClockLower} <= 4'h0;
        tick(3);
    endtask : pulse

    task automatic drive(input iop_pkg::iop_cfg_s c, input logic d);
        for (int i = 0; i < iop_pkg::NUM_ELEM; i++) elemCfg[i] <= c;
        padIn <= d;
        outData <= {d, d};
        triData <= {d, d};
    endtask : drive

    task automatic global_pulse;
        globalSetReset <= 1'h1;
        tick(2);
        globalSetReset <= 1'h0;
        tick(2);
    endtask : global_pulse

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, outCe, triCe, inCe} = 4'hf;
        {inClockUpper, inClockLower, setResetLine, reverseForceLine} = 4'h0;
        {globalSetReset, outDualEdge, triDualEdge, padIn, dualRun, manUpper, manLower} = 7'h00;
        {outData, triData, elemCfg} = '0;
        error_cnt = 0;
        samples_checked = 0;
        tick(2);
        check(elems(), 6'h00, "held in reset");
        rst <= 1'h0;
        tick(2);
        check(elems(), 6'h00, "initial zero after release");
        for (k = 0; k < 10; k++) begin
            drive(rows[k].c, rows[k].d);
            {setResetLine, reverseForceLine} <= {rows[k].fwd, rows[k].inv};
            pulse(4'hf);
            check(elems(), {6{rows[k].q}}, "row result");
        end
        {setResetLine, reverseForceLine} <= 2'h0;
        for (k = 0; k < 3; k++) begin
            drive(5'h00, 1'h0);
            pulse(4'hf);
            {triCe, outCe, inCe} <= ~(3'h1 << k);
            drive(5'h00, 1'h1);
            pulse(4'hf);
            check(elems(), 6'h3f & ~(6'h03 << (2 * k)), "pair enable");
            {triCe, outCe, inCe} <= 3'h7;
        end
        drive(5'h00, 1'h0);
        pulse(4'hf);
        drive(5'h00, 1'h1);
        for (k = 0; k < 4; k++) begin
            pulse(clkMask[k]);
            check(elems(), clkExp[k], "clock routing");
        end
        setResetLine <= 1'h1;
        tick(4);
        check(elems(), 6'h3f, "sync force waits for clock line");
        drive(5'h08, 1'h1);
        tick(4);
        check(elems(), 6'h00, "async force without clock line");
        setResetLine <= 1'h0;
        drive(5'h04, 1'h0);
        global_pulse();
        check(elems(), 6'h3f, "global init follows set polarity");
        drive(5'h06, 1'h0);
        global_pulse();
        check(elems(), 6'h00, "global init override");
        drive(5'h10, 1'h1);
        inClockUpper <= 1'h1;
        tick(3);
        check(elems() & 6'h01, 6'h01, "latch open passes");
        padIn <= 1'h0;
        tick(3);
        check(elems() & 6'h01, 6'h00, "latch follows");
        inClockUpper <= 1'h0;
        tick(2);
        padIn <= 1'h1;
        tick(3);
        check(elems() & 6'h01, 6'h00, "latch closed holds");
        drive(5'h00, 1'h0);
        elemCfg[iop_pkg::IDX_OUT_UP] <= 5'h04;
        outDualEdge <= 1'h1;
        setResetLine <= 1'h1;
        pulse(4'hc);
        check(6'(outStored), 6'h03, "dual pair takes upper polarity");
        setResetLine <= 1'h0;
        elemCfg[iop_pkg::IDX_OUT_UP] <= 5'h02;
        elemCfg[iop_pkg::IDX_OUT_LO] <= 5'h03;
        global_pulse();
        check(6'(outStored), 6'h00, "dual initial zero whole pair");
        drive(5'h00, 1'h0);
        outData <= 2'h2;
        dualRun <= 1'h1;
        triDualEdge <= 1'h1;
        flips = 0;
        tick(8);
        prevOut = padOut;
        repeat (40) begin
            tick(1);
            if (padOut !== prevOut) flips++;
            prevOut = padOut;
        end
        check(6'(flips >= 16), 6'h01, "dual edge output alternates");
        check(6'(padOutEnable), 6'h01, "driver on while tri bit low");
        outDualEdge <= 1'h0;
        triData <= 2'h3;
        tick(10);
        check(6'({padOut, padOutEnable}), 6'h02, "plain pair shows upper");
        dualRun <= 1'h0;
        drive(5'h04, 1'h0);
        rst <= 1'h1;
        tick(2);
        check(elems(), 6'h00, "second reset clears");
        rst <= 1'h0;
        tick(2);
        check(elems(), 6'h3f, "initial one after second release");
        results();
    end

    initial begin
        #200000;
        error_cnt++;
        results();
    end
endmodule : io_pad_storage_registers_bench
